/* File: src/spao_pkg.sv */
package spao_pkg;

  // ==========================================================
  // Register map (APB byte offsets)
  localparam logic [7:0] SPAO_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SPAO_SETPT_OFS  = 8'h04;
  localparam logic [7:0] SPAO_HYST_OFS   = 8'h08;
  localparam logic [7:0] SPAO_DLY_OFS    = 8'h0C;
  localparam logic [7:0] SPAO_VALUE_OFS  = 8'h10;
  localparam logic [7:0] SPAO_STAT_OFS   = 8'h14;
  localparam logic [7:0] SPAO_IRQ_OFS    = 8'h18;
  localparam logic [7:0] SPAO_MASK_OFS   = 8'h1C;

  // ==========================================================
  // Control field positions
  localparam int SPAO_C_EN     = 0;
  localparam int SPAO_C_LOW    = 1;
  localparam int SPAO_C_UNBAL  = 2;
  localparam int SPAO_C_RST0   = 3;
  localparam int SPAO_C_RST1   = 4;
  localparam int SPAO_C_RDR    = 5;
  localparam int SPAO_C_STBY   = 6;
  localparam int SPAO_C_SHOWN  = 7;
  localparam int SPAO_C_INPVW  = 8;
  localparam int SPAO_CTRL_W   = 9;

  // ==========================================================
  // Status and interrupt bits
  localparam int SPAO_I_ON     = 0;
  localparam int SPAO_I_OFF    = 1;
  localparam int SPAO_I_RST    = 2;
  localparam int SPAO_I_RANGE  = 3;
  localparam int SPAO_IRQ_W    = 4;

  // ==========================================================
  // Value ranges
  localparam logic signed [31:0] SPAO_SETPT_MIN = -32'sd19999;
  localparam logic signed [31:0] SPAO_SETPT_MAX = 32'sd99999;
  localparam logic [15:0]        SPAO_HYST_MIN  = 16'h0001;
  localparam logic [15:0]        SPAO_HYST_MAX  = 16'hEA5F;
  localparam logic [15:0]        SPAO_HYST_RST  = 16'h0001;
  localparam logic [12:0]        SPAO_DLY_MAX   = 13'h176F;

  // ==========================================================
  // Timing: delays count in tenths of a second
  localparam int  SPAO_CLK_MHZ      = 250;
  localparam int  SPAO_TICK_MS      = 100;
  localparam int  SPAO_TICK_CYCLES  = SPAO_TICK_MS * 1000 * SPAO_CLK_MHZ;
  localparam int  SPAO_SYNC_STAGES  = 2;

  typedef enum logic [1:0] {
    SPAO_AUTO,
    SPAO_LATCH_NOW,
    latch_deferred_clear_rst
  } spao_rst_e;

endpackage : spao_pkg

/* File: src/spao_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Delay timer request / status bundle
interface spao_tmr_if;
  logic        run;
  logic [12:0] limit;
  logic        tick;
  logic        done;
  modport ctl (output run, output limit, input tick, input done);
  modport tmr (input run, input limit, output tick, output done);
endinterface : spao_tmr_if
`default_nettype wire

/* File: src/spao_delay.sv */
`timescale 1ns/1ps
`default_nettype none
module spao_delay #(
  parameter int TICK_CYCLES = spao_pkg::SPAO_TICK_CYCLES
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  spao_tmr_if.tmr    t
);
  import spao_pkg::*;

  typedef struct packed {
    logic [31:0] pre;
    logic [12:0] cnt;
    logic        tick;
    logic        done;
  } spao_dly_s;

  spao_dly_s s_q;
  spao_dly_s s_d;

  // ==========================================================
  // Tenth-second counter; any drop of run restarts it
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!t.run) begin
      s_d.pre  = '0;
      s_d.cnt  = '0;
      s_d.done = 1'b0;
    end else if (s_q.cnt >= t.limit) begin
      s_d.done = 1'b1;
    end else if (s_q.pre == 32'(TICK_CYCLES - 1)) begin
      s_d.pre  = '0;
      s_d.cnt  = s_q.cnt + 13'h0001;
      s_d.tick = 1'b1;
    end else begin
      s_d.pre = s_q.pre + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.tick = s_q.tick;
  assign t.done = s_q.done;
endmodule : spao_delay
`default_nettype wire

/* File: src/spao_top.sv */
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Four actions: high or low acting, balanced or unbalanced hysteresis.
// - Setpoint is signed, accepted from -19999 to 99999.
// - Setpoint and hysteresis share the display value's decimal scaling.
// - Hysteresis is programmable from 1 to 59999 counts.
// - Unbalanced band below setpoint for high acting, above for low.
// - On delay postpones activation; zero delay acts on the next update.
// - Off delay from 0.0 to 599.9 s postpones deactivation, applied under auto action only.
// - Auto action turns off at trigger; manual reset forces off until recrossed.
// - Immediate latch holds on until manual reset, which clears it at once.
// - Deferred latch remembers reset and clears at the off point.
// - At power-up a latched output starts off outside the alarm region.
// - With reset-with-display enabled, display reset also resets the output.
// - Display reset acts only for shown-display assignment with input value shown.
// - Standby holds output off after power-up until trigger is first crossed.
// - Manual reset is momentary and blocks re-activation until the value leaves the on region.
// - A disabled setpoint keeps its output off.
module spao_top #(
  parameter int TICK_CYCLES = spao_pkg::SPAO_TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rst_button,
  input  wire logic        user_input,
  output logic             relay_out,
  output logic             irq
);
  import spao_pkg::*;

  typedef struct packed {
    logic [SPAO_CTRL_W-1:0] ctrl;
    logic signed [31:0]     setpt;
    logic [15:0]            hyst;
    logic [12:0]            on_dly;
    logic [12:0]            off_dly;
    logic signed [31:0]     value;
    logic                   upd;
    logic                   cond_on;
    logic                   cond_off;
    logic                   out;
    logic                   armed;
    logic                   valid;
    logic                   rst_pend;
    logic                   inhibit;
    logic [1:0]             btn_s;
    logic [1:0]             usr_s;
    logic                   btn_l;
    logic                   usr_l;
    logic [SPAO_IRQ_W-1:0]  sts;
    logic [SPAO_IRQ_W-1:0]  mask;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   err;
    logic                   irq;
  } spao_top_s;

  spao_top_s s_q;
  spao_top_s s_d;

  // ==========================================================
  // Delay timers; each restarts whenever its request drops
  spao_tmr_if on_t ();
  spao_tmr_if off_t ();

  spao_delay #(.TICK_CYCLES(TICK_CYCLES)) u_on (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (on_t)
  );
  spao_delay #(.TICK_CYCLES(TICK_CYCLES)) u_off (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (off_t)
  );

  // ==========================================================
  // Helpers
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  // Delays above the top count saturate rather than wrap to a short delay
  function automatic logic [12:0] clip_dly(input logic [15:0] v);
    clip_dly = (v > 16'(SPAO_DLY_MAX)) ? SPAO_DLY_MAX : v[12:0];
  endfunction : clip_dly

  // Offsets that exist; any other address is refused with pslverr
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      SPAO_CTRL_OFS,
      SPAO_SETPT_OFS,
      SPAO_HYST_OFS,
      SPAO_DLY_OFS,
      SPAO_VALUE_OFS,
      SPAO_STAT_OFS,
      SPAO_IRQ_OFS,
      SPAO_MASK_OFS: addr_mapped = 1'b1;
      default:       addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // Rising edge of a synchronised level against its value one edge earlier
  function automatic logic rose_lvl(input logic now_v, input logic last_v);
    rose_lvl = now_v && !last_v;
  endfunction : rose_lvl

  // ==========================================================
  // Signals not held in state
  logic signed [31:0] hi_pt;
  logic signed [31:0] lo_pt;
  logic signed [31:0] half;
  logic               man_rst;
  logic               disp_rst;
  logic               wr;
  logic               rd;
  logic [1:0]         ract;
  logic               stby_hold;
  logic [SPAO_IRQ_W-1:0] ev;

  // ==========================================================
  // Trigger points from setpoint, hysteresis and action
  always_comb begin
    // Thresholds share display scaling; no decimal handling here
    half = 32'(s_q.hyst >> 1);
    if (s_q.ctrl[SPAO_C_UNBAL]) begin
      hi_pt = s_q.ctrl[SPAO_C_LOW] ? s_q.setpt + 32'(s_q.hyst) : s_q.setpt;
      lo_pt = s_q.ctrl[SPAO_C_LOW] ? s_q.setpt : s_q.setpt - 32'(s_q.hyst);
    end else begin
      hi_pt = s_q.setpt + (32'(s_q.hyst) - half);
      lo_pt = s_q.setpt - half;
    end
  end

  // ==========================================================
  // Bus strobes, reset sources and timer requests
  assign wr   = psel && penable && pwrite;
  assign rd   = psel && !penable && !pwrite;
  assign ract = {s_q.ctrl[SPAO_C_RST1], s_q.ctrl[SPAO_C_RST0]};

  // Reset sources are edges of synchronised button and user input levels
  assign man_rst  = rose_lvl(s_q.btn_s[1], s_q.btn_l) || rose_lvl(s_q.usr_s[1], s_q.usr_l);
  // An edge that the display gating refuses is dropped, not remembered
  assign disp_rst = man_rst && s_q.ctrl[SPAO_C_RDR] && s_q.ctrl[SPAO_C_SHOWN]
                    && s_q.ctrl[SPAO_C_INPVW];

  // Standby only holds back activation while it is enabled
  assign stby_hold   = s_q.inhibit && s_q.ctrl[SPAO_C_STBY];
  assign on_t.run    = s_q.cond_on && !s_q.out && s_q.armed;
  assign on_t.limit  = s_q.on_dly;
  assign off_t.run   = s_q.cond_off && s_q.out && (ract == 2'(SPAO_AUTO));
  assign off_t.limit = s_q.off_dly;

  // ==========================================================
  // Next state
  always_comb begin
    s_d       = s_q;
    ev        = '0;
    s_d.upd   = 1'b0;
    // Two-stage synchronisers; only the second stage feeds any logic
    s_d.btn_s = {s_q.btn_s[0], rst_button};
    s_d.usr_s = {s_q.usr_s[0], user_input};
    s_d.btn_l = s_q.btn_s[1];
    s_d.usr_l = s_q.usr_s[1];

    // Comparison refreshed only on the update after a value write
    if (s_q.upd) begin
      s_d.cond_on  = s_q.ctrl[SPAO_C_LOW] ? (s_q.value <= lo_pt) : (s_q.value >= hi_pt);
      s_d.cond_off = s_q.ctrl[SPAO_C_LOW] ? (s_q.value >= hi_pt) : (s_q.value <= lo_pt);
      s_d.valid    = 1'b1;
      if (!s_q.valid) begin
        // First sample after power-up: latched outputs come up off here
        s_d.out = 1'b0;
      end
    end

    // Standby ends at the first sample outside the on region, so only a
    // later entry into the alarm region counts as crossing the trigger
    if (s_q.inhibit && s_q.valid && !s_q.cond_on) begin
      s_d.inhibit = 1'b0;
    end

    // ========================================================
    // Activation, re-armed once the value leaves the on region
    if (on_t.done && s_q.armed && !stby_hold) begin
      s_d.out = 1'b1;
      ev[SPAO_I_ON] = 1'b1;
    end

    // Reset action decides how an active output goes off
    if (s_q.out) begin
      case (spao_rst_e'(ract))
        SPAO_AUTO: begin
          if (off_t.done) begin
            s_d.out = 1'b0;
            ev[SPAO_I_OFF] = 1'b1;
          end
          if (disp_rst) begin
            s_d.out   = 1'b0;
            s_d.armed = 1'b0;
            ev[SPAO_I_RST] = 1'b1;
          end
        end
        SPAO_LATCH_NOW: begin
          if (disp_rst) begin
            s_d.out   = 1'b0;
            s_d.armed = 1'b0;
            ev[SPAO_I_RST] = 1'b1;
          end
        end
        latch_deferred_clear_rst: begin
          if (disp_rst) begin
            s_d.rst_pend = 1'b1;
          end
          if (s_q.rst_pend && s_q.cond_off) begin
            s_d.out      = 1'b0;
            s_d.rst_pend = 1'b0;
            ev[SPAO_I_OFF] = 1'b1;
          end
        end
        default: begin
          s_d.out = 1'b0;
        end
      endcase
    end

    // Re-arm when value leaves the on region; a reset blocks activation only until then
    if (!s_q.armed && !s_q.cond_on) begin
      s_d.armed = 1'b1;
    end
    if (!s_q.out && !s_q.rst_pend) begin
      s_d.rst_pend = 1'b0;
    end

    if (!s_q.ctrl[SPAO_C_EN]) begin
      s_d.out      = 1'b0;
      s_d.rst_pend = 1'b0;
    end

    // ========================================================
    // APB slave: zero wait states, error on unmapped or out-of-range
    s_d.ready = psel && !penable;
    s_d.err   = 1'b0;
    if (psel && !penable) begin
      s_d.err = !addr_mapped(paddr);
      if (pwrite && addr_hit(paddr, SPAO_SETPT_OFS)
          && (($signed(pwdata) < SPAO_SETPT_MIN) || ($signed(pwdata) > SPAO_SETPT_MAX))) begin
        s_d.err = 1'b1;
      end
      if (pwrite && addr_hit(paddr, SPAO_HYST_OFS)
          && ((pwdata[15:0] < SPAO_HYST_MIN) || (pwdata[15:0] > SPAO_HYST_MAX)
              || (pwdata[31:16] != 16'h0000))) begin
        s_d.err = 1'b1;
      end
    end
    // Writes land on the access edge, only if setup raised no error
    if (wr && !s_q.err) begin
      if (addr_hit(paddr, SPAO_CTRL_OFS)) begin
        s_d.ctrl = pwdata[SPAO_CTRL_W-1:0];
      end
      if (addr_hit(paddr, SPAO_SETPT_OFS)) begin
        s_d.setpt = $signed(pwdata);
      end
      if (addr_hit(paddr, SPAO_HYST_OFS)) begin
        s_d.hyst = pwdata[15:0];
      end
      if (addr_hit(paddr, SPAO_DLY_OFS)) begin
        s_d.on_dly  = clip_dly(pwdata[15:0]);
        s_d.off_dly = clip_dly(pwdata[31:16]);
      end
      if (addr_hit(paddr, SPAO_VALUE_OFS)) begin
        s_d.value = $signed(pwdata);
        s_d.upd   = 1'b1;
      end
      if (addr_hit(paddr, SPAO_MASK_OFS)) begin
        s_d.mask = pwdata[SPAO_IRQ_W-1:0];
      end
      if (addr_hit(paddr, SPAO_IRQ_OFS)) begin
        s_d.sts = s_q.sts & ~pwdata[SPAO_IRQ_W-1:0];
      end
    end
    // A refused write is reported as a range event
    if (wr && s_q.err) begin
      ev[SPAO_I_RANGE] = 1'b1;
    end

    // Set beats clear in the same cycle
    s_d.sts = s_d.sts | ev;
    s_d.irq = |(s_d.sts & s_d.mask);

    // ========================================================
    // Read data, registered so it stands in the access cycle
    s_d.rdata = '0;
    if (rd) begin
      case (paddr)
        SPAO_CTRL_OFS:  s_d.rdata = 32'(s_q.ctrl);
        SPAO_SETPT_OFS: s_d.rdata = s_q.setpt;
        SPAO_HYST_OFS:  s_d.rdata = 32'(s_q.hyst);
        SPAO_DLY_OFS:   s_d.rdata = {3'h0, s_q.off_dly, 3'h0, s_q.on_dly};
        SPAO_VALUE_OFS: s_d.rdata = s_q.value;
        SPAO_STAT_OFS:  s_d.rdata = {26'h0, s_q.inhibit, s_q.rst_pend, s_q.armed,
                                     s_q.cond_off, s_q.cond_on, s_q.out};
        SPAO_IRQ_OFS:   s_d.rdata = 32'(s_q.sts);
        SPAO_MASK_OFS:  s_d.rdata = 32'(s_q.mask);
        default:        s_d.rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // State register; inhibit wakes set so standby covers the first samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      s_q.hyst    <= SPAO_HYST_RST;
      s_q.armed   <= 1'b1;
      s_q.inhibit <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs come straight from state flip-flops
  assign prdata    = s_q.rdata;
  assign pready    = s_q.ready;
  assign pslverr   = s_q.err;
  assign relay_out = s_q.out;
  assign irq       = s_q.irq;

endmodule : spao_top
`default_nettype wire

/* File: tb/spao_load.sv */
`timescale 1ns/1ps
`default_nettype none
module spao_load (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       relay_out,
  output logic      [7:0] on_cnt_q
);
  logic was_on_q;
  // ====================
  // Load energise count
  // Chatter on the contact shows up as extra counts, not as a glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      was_on_q <= 1'b0;
      on_cnt_q <= 8'h00;
    end else begin
      was_on_q <= relay_out;
      if (relay_out && !was_on_q) on_cnt_q <= on_cnt_q + 8'h01;
    end
  end
endmodule : spao_load
`default_nettype wire

/* File: tb/spao_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module spao_top_sva #(
  parameter int TICK_CYCLES = spao_pkg::SPAO_TICK_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rst_button,
  input wire logic        user_input,
  input wire logic        relay_out,
  input wire logic        irq
);
  import spao_pkg::*;
  logic [8:0] ctrl_q;
  // ====================
  // Control shadow
  // Only accepted writes count, so a refused access cannot skew it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_q <= 9'h000;
    else if (psel && penable && pwrite && pready && !pslverr && paddr == SPAO_CTRL_OFS)
      ctrl_q <= pwdata[8:0];
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====================
  // Properties
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  AST_RDY_ONLY: assert property (pready |-> psel && penable)
    else $error("ready outside access cycle");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAP: assert property (psel && !penable && paddr > SPAO_MASK_OFS |=> pslverr)
    else $error("unmapped access not refused");
  AST_SETPT: assert property (psel && !penable && pwrite && paddr == SPAO_SETPT_OFS
    |=> pslverr == ($signed(pwdata) < SPAO_SETPT_MIN || $signed(pwdata) > SPAO_SETPT_MAX))
    else $error("setpoint range check wrong");
  AST_HYST: assert property (psel && !penable && pwrite && paddr == SPAO_HYST_OFS
    && pwdata[31:16] == 16'h0000
    |=> pslverr == (pwdata[15:0] < SPAO_HYST_MIN || pwdata[15:0] > SPAO_HYST_MAX))
    else $error("hysteresis range check wrong");
  AST_OFF_DIS: assert property (!ctrl_q[SPAO_C_EN] [*4] |-> !relay_out)
    else $error("disabled output on");
  AST_MRST: assert property (($rose(rst_button) || $rose(user_input))
    && ctrl_q[SPAO_C_EN] && !ctrl_q[SPAO_C_RST1] && ctrl_q[SPAO_C_RDR]
    && ctrl_q[SPAO_C_SHOWN] && ctrl_q[SPAO_C_INPVW] |-> ##[1:8] !relay_out)
    else $error("manual reset left output on");
endmodule : spao_top_sva

bind spao_top spao_top_sva #(.TICK_CYCLES(TICK_CYCLES)) spao_top_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rst_button(rst_button),
  .user_input(user_input), .relay_out(relay_out), .irq(irq)
);
`default_nettype wire

/* File: tb/spao_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module spao_top_bench;
  import spao_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rst_button = 1'b0;
  logic        user_input = 1'b0;
  logic        relay_out;
  logic        irq;
  logic [7:0]  on_cnt;
  int          fails = 0;
  int          samples_checked = 0;
  always #2 pclk = ~pclk;
  spao_top #(.TICK_CYCLES(4)) spao_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rst_button(rst_button),
    .user_input(user_input), .relay_out(relay_out), .irq(irq));
  spao_load spao_load_i (
    .pclk(pclk), .presetn(presetn), .relay_out(relay_out), .on_cnt_q(on_cnt));
  task automatic summarize();
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
    samples_checked++;
    if (got !== x) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, x);
    end
  endtask : chk
  // ====================
  // Bus access; one idle edge after each so strobes never toggle twice at once
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic ee, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      summarize();
    end
    r = prdata;
    chk({31'h0, pslverr}, {31'h0, ee}, "resp");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    apb(a, 1'b1, d, ee, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    apb(a, 1'b0, 32'h0, 1'b0, r);
    chk(r, x, "read");
  endtask : rd
  task automatic vr(input int v, input logic e);
    wr(SPAO_VALUE_OFS, 32'(v), 1'b0);
    repeat (12) @(posedge pclk);
    chk({31'h0, relay_out}, {31'h0, e}, "relay");
  endtask : vr
  task automatic tw(input int v, input logic e);
    int n;
    n = 0;
    wr(SPAO_VALUE_OFS, 32'(v), 1'b0);
    while (relay_out !== e && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= 12 && n < 100), 32'h1, "delay");
  endtask : tw
  task automatic pulse(input logic b, input logic e);
    rst_button <= b;
    user_input <= !b;
    repeat (4) @(posedge pclk);
    rst_button <= 1'b0;
    user_input <= 1'b0;
    repeat (12) @(posedge pclk);
    chk({31'h0, relay_out}, {31'h0, e}, "reset");
  endtask : pulse
  // ====================
  // Main sequence
  initial begin : main
    int s, on_v, off_v;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SPAO_CTRL_OFS, 32'h0);
    rd(SPAO_HYST_OFS, 32'h1);
    rd(SPAO_DLY_OFS, 32'h0);
    rd(SPAO_MASK_OFS, 32'h0);
    wr(8'h20, 32'h0, 1'b1);
    wr(SPAO_SETPT_OFS, SPAO_SETPT_MIN, 1'b0);
    wr(SPAO_SETPT_OFS, SPAO_SETPT_MIN - 1, 1'b1);
    wr(SPAO_SETPT_OFS, SPAO_SETPT_MAX + 1, 1'b1);
    wr(SPAO_SETPT_OFS, SPAO_SETPT_MAX, 1'b0);
    wr(SPAO_HYST_OFS, 32'h0, 1'b1);
    wr(SPAO_HYST_OFS, {16'h0, SPAO_HYST_MAX}, 1'b0);
    wr(SPAO_HYST_OFS, {16'h0, SPAO_HYST_MAX + 16'h1}, 1'b1);
    rd(SPAO_HYST_OFS, {16'h0, SPAO_HYST_MAX});
    wr(SPAO_SETPT_OFS, 32'h64, 1'b0);
    wr(SPAO_HYST_OFS, 32'hA, 1'b0);
    for (int m = 0; m < 4; m++) begin
      s = m[0] ? -1 : 1;
      on_v = 100 + (m[1] ? 0 : 5 * s);
      off_v = on_v - 10 * s;
      wr(SPAO_CTRL_OFS, 32'(1 + 2 * m), 1'b0);
      vr(on_v - s, 1'b0);
      vr(on_v, 1'b1);
      vr(off_v + s, 1'b1);
      vr(off_v, 1'b0);
    end
    rd(SPAO_IRQ_OFS, 32'hB);
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr(SPAO_MASK_OFS, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "irq");
    wr(SPAO_IRQ_OFS, 32'hF, 1'b0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    wr(SPAO_CTRL_OFS, 32'h5, 1'b0);
    wr(SPAO_DLY_OFS, 32'h0005_0005, 1'b0);
    wr(SPAO_VALUE_OFS, 32'h64, 1'b0);
    repeat (3) @(posedge pclk);
    chk({31'h0, relay_out}, 32'h0, "on delay");
    vr(95, 1'b0);
    tw(100, 1'b1);
    tw(90, 1'b0);
    wr(SPAO_DLY_OFS, 32'h0, 1'b0);
    wr(SPAO_CTRL_OFS, 32'h1A5, 1'b0);
    vr(100, 1'b1);
    pulse(1'b1, 1'b0);
    vr(101, 1'b0);
    vr(80, 1'b0);
    vr(100, 1'b1);
    vr(80, 1'b0);
    wr(SPAO_CTRL_OFS, 32'h1AD, 1'b0);
    vr(100, 1'b1);
    vr(80, 1'b1);
    pulse(1'b0, 1'b0);
    vr(100, 1'b1);
    pulse(1'b1, 1'b0);
    wr(SPAO_CTRL_OFS, 32'h1B5, 1'b0);
    vr(80, 1'b0);
    vr(100, 1'b1);
    pulse(1'b1, 1'b1);
    vr(95, 1'b1);
    vr(90, 1'b0);
    vr(100, 1'b1);
    vr(80, 1'b1);
    wr(SPAO_CTRL_OFS, 32'h0, 1'b0);
    vr(100, 1'b0);
    chk({24'h0, on_cnt}, 32'hB, "on count");
    // Mid-run reset, then standby with the first sample inside the on region
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, relay_out}, 32'h0, "reset relay");
    wr(SPAO_SETPT_OFS, 32'h64, 1'b0);
    wr(SPAO_HYST_OFS, 32'hA, 1'b0);
    wr(SPAO_CTRL_OFS, 32'h4D, 1'b0);
    vr(100, 1'b0);
    vr(80, 1'b0);
    vr(100, 1'b1);
    wr(SPAO_CTRL_OFS, 32'h12D, 1'b0);
    pulse(1'b1, 1'b1);
    chk({24'h0, on_cnt}, 32'h1, "standby count");
    summarize();
  end
endmodule : spao_top_bench
`default_nettype wire
